/* File: rtl/pef_pkg.sv */
package pef_pkg;

    // Register byte addresses
    localparam logic [7:0] PEF_FLAGS_ADDR = 8'h0C;
    localparam logic [7:0] PEF_IRQ_STATUS_ADDR = 8'h10;
    localparam logic [7:0] PEF_IRQ_MASK_ADDR = 8'h14;

    // Field positions of the flag register
    localparam int PEF_NV_WRITE_DONE_BIT = 7;
    localparam int PEF_COMPARATOR_CHANGE_BIT = 6;
    localparam int PEF_SERIAL_RX_FULL_BIT = 5;
    localparam int PEF_SERIAL_TX_EMPTY_BIT = 4;
    localparam int PEF_UNIMPL_BIT = 3;
    localparam int PEF_CAPTURE_COMPARE_BIT = 2;
    localparam int PEF_PERIOD_MATCH_BIT = 1;
    localparam int PEF_WIDE_TIMER_OVF_BIT = 0;

    // Reset values and access masks
    localparam logic [7:0] PEF_FLAGS_RESET = 8'h00;
    localparam logic [7:0] PEF_IRQ_STATUS_RESET = 8'h00;
    localparam logic [7:0] PEF_IRQ_MASK_RESET = 8'h00;
    localparam logic [7:0] PEF_STICKY_MASK = 8'hC7;
    localparam logic [7:0] PEF_IMPL_MASK = 8'hF7;

    // Register bus command
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pef_bus_req_t;

    // Peripheral event pulses and buffer levels
    typedef struct packed {
        logic nv_write_done;
        logic comparator_result;
        logic serial_rx_full;
        logic serial_tx_empty;
        logic capture_compare_event;
        logic pwm_mode;
        logic period_match;
        logic wide_timer_overflow;
    } pef_periph_t;

endpackage

/* File: rtl/pef_flags.sv */
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps

// Overview of operation
// - All peripheral event flags sit in one 8-bit register at address 0x0C with bit 3 unimplemented.
// - The nonvolatile write done flag sets when a data EEPROM write finishes and stays set until software clears it.
// - The comparator change flag sets whenever the comparator result changes.
// - The serial receive flag is read-only and is high exactly while the receive buffer holds data.
// - The serial transmit flag is read-only and is high exactly while the transmit buffer is empty.
// - Each flag sets on its event regardless of any enable bit or the global interrupt enable.
module pef_flags (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire pef_pkg::pef_bus_req_t bus_req_in,
    input wire pef_pkg::pef_periph_t periph_in,
    output logic [7:0] rd_data_out,
    output logic irq_out
);
    import pef_pkg::*;

    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] irq_status_q;
    logic [7:0] irq_status_d;
    logic [7:0] irq_mask_q;
    logic [7:0] rd_data_q;
    logic [7:0] flags_view;
    logic [7:0] events;
    logic cmp_prev_q;
    logic rx_prev_q;
    logic tx_prev_q;
    logic primed_q;
    logic flags_wr;
    logic status_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Event detection

    // Edge history; first enabled cycle only primes it, so no false change
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            cmp_prev_q <= 1'b0;
            rx_prev_q <= 1'b0;
            tx_prev_q <= 1'b0;
            primed_q <= 1'b0;
        end else if (clk_en_in) begin
            cmp_prev_q <= periph_in.comparator_result;
            rx_prev_q <= periph_in.serial_rx_full;
            tx_prev_q <= periph_in.serial_tx_empty;
            primed_q <= 1'b1;
        end
    end

    // One event vector in flag layout, no enable gating anywhere
    always_comb begin
        events = 8'h00;
        events[PEF_NV_WRITE_DONE_BIT] = periph_in.nv_write_done;
        events[PEF_COMPARATOR_CHANGE_BIT] = primed_q && (periph_in.comparator_result != cmp_prev_q);
        events[PEF_SERIAL_RX_FULL_BIT] = primed_q && periph_in.serial_rx_full && !rx_prev_q;
        events[PEF_SERIAL_TX_EMPTY_BIT] = primed_q && periph_in.serial_tx_empty && !tx_prev_q;
        events[PEF_CAPTURE_COMPARE_BIT] = periph_in.capture_compare_event && !periph_in.pwm_mode;
        events[PEF_PERIOD_MATCH_BIT] = periph_in.period_match;
        events[PEF_WIDE_TIMER_OVF_BIT] = periph_in.wide_timer_overflow;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Flag register

    // Address decode of the strobes
    assign flags_wr = bus_req_in.wr && (bus_req_in.addr == PEF_FLAGS_ADDR);
    assign status_rd = bus_req_in.rd && (bus_req_in.addr == PEF_IRQ_STATUS_ADDR);

    // Sticky bits: software write first, then events OR in so set wins
    always_comb begin
        flags_d = flags_q;
        if (flags_wr) begin
            flags_d = bus_req_in.wdata & PEF_STICKY_MASK;
        end
        flags_d = flags_d | (events & PEF_STICKY_MASK);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            flags_q <= PEF_FLAGS_RESET;
        end else if (clk_en_in) begin
            flags_q <= flags_d;
        end
    end

    // Serial bits mirror buffer levels; bit 3 stays zero
    always_comb begin
        flags_view = flags_q & PEF_STICKY_MASK;
        flags_view[PEF_SERIAL_RX_FULL_BIT] = periph_in.serial_rx_full;
        flags_view[PEF_SERIAL_TX_EMPTY_BIT] = periph_in.serial_tx_empty;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status and mask

    // Read clears status, but a same-cycle event still lands
    always_comb begin
        irq_status_d = irq_status_q;
        if (status_rd) begin
            irq_status_d = 8'h00;
        end
        irq_status_d = irq_status_d | (events & PEF_IMPL_MASK);
    end

    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            irq_status_q <= PEF_IRQ_STATUS_RESET;
        end else if (clk_en_in) begin
            irq_status_q <= irq_status_d;
        end
    end

    // Mask register, same layout as status
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            irq_mask_q <= PEF_IRQ_MASK_RESET;
        end else if (clk_en_in && bus_req_in.wr && (bus_req_in.addr == PEF_IRQ_MASK_ADDR)) begin
            irq_mask_q <= bus_req_in.wdata & PEF_IMPL_MASK;
        end
    end

    // Level output straight from registers
    assign irq_out = |(irq_status_q & irq_mask_q);

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    // Data valid in the cycle after an enabled read strobe, and held while clk_en_in stays low
    always_ff @(posedge sys_clk_in) begin
        if (!resetn_in) begin
            rd_data_q <= 8'h00;
        end else if (clk_en_in) begin
            if (!bus_req_in.rd) begin
                rd_data_q <= 8'h00;
            end else if (bus_req_in.addr == PEF_FLAGS_ADDR) begin
                rd_data_q <= flags_view;
            end else if (bus_req_in.addr == PEF_IRQ_STATUS_ADDR) begin
                rd_data_q <= irq_status_q;
            end else if (bus_req_in.addr == PEF_IRQ_MASK_ADDR) begin
                rd_data_q <= irq_mask_q;
            end else begin
                rd_data_q <= 8'h00; // Unmapped reads as zero
            end
        end
    end

    assign rd_data_out = rd_data_q;

endmodule

/* File: sim/pef_flags_assertions.sv */
`timescale 1ns/10ps
module pef_flags_assertions (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic clk_en_in,
    input wire pef_pkg::pef_bus_req_t bus_req_in,
    input wire pef_pkg::pef_periph_t periph_in,
    input wire logic [7:0] rd_data_out,
    input wire logic irq_out
);
    import pef_pkg::*;
    logic rdf;
    // Flag read taken
    assign rdf = clk_en_in && bus_req_in.rd && bus_req_in.addr == PEF_FLAGS_ADDR;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!resetn_in);
    rd_idle_a: assert property (clk_en_in && !bus_req_in.rd |=> rd_data_out == 8'h00)
        else $error("read data not idle");
    unimpl_zero_a: assert property (rdf |=> !rd_data_out[3])
        else $error("bit 3 set");
    rx_live_a: assert property (rdf |=> rd_data_out[5] == $past(periph_in.serial_rx_full))
        else $error("rx flag wrong");
    tx_live_a: assert property (rdf |=> rd_data_out[4] == $past(periph_in.serial_tx_empty))
        else $error("tx flag wrong");
    nv_done_a: assert property (clk_en_in && periph_in.nv_write_done ##1 rdf |=> rd_data_out[7])
        else $error("write done lost");
    cmp_change_a: assert property ($past(resetn_in) && $past(clk_en_in) && clk_en_in
        && $changed(periph_in.comparator_result) ##1 rdf |=> rd_data_out[6]) else $error("change lost");
    ccp_event_a: assert property (clk_en_in && periph_in.capture_compare_event && !periph_in.pwm_mode
        ##1 rdf |=> rd_data_out[2]) else $error("capture lost");
    timer_flags_a: assert property (clk_en_in && periph_in.period_match && periph_in.wide_timer_overflow
        ##1 rdf |=> rd_data_out[1:0] == 2'b11) else $error("timer flags lost");
    cover property (rdf ##1 rd_data_out[7]);
    cover property (irq_out);
    cover property (!clk_en_in ##1 rdf);
endmodule
bind pef_flags pef_flags_assertions u_chk (.sys_clk_in, .resetn_in, .clk_en_in, .bus_req_in, .periph_in,
    .rd_data_out, .irq_out);

/* File: sim/pef_flags_tb.sv */
`timescale 1ns/10ps
module pef_flags_tb;
    import pef_pkg::*;
    logic sys_clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic clk_en_in = 1'b1;
    pef_bus_req_t bus_req_in = '0;
    pef_periph_t periph_in = '0;
    logic [7:0] rd_data_out, got, model, p;
    logic irq_out, en, cmp_q;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;
    int seed = 73;
    pef_flags DUT (.sys_clk_in, .resetn_in, .clk_en_in, .bus_req_in, .periph_in, .rd_data_out, .irq_out);
    // Clock, and a hang guard well above the run length
    initial begin
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        if (++cycles == 3000) begin
            failures++;
            results();
        end
    end
    //////////////////////////////////////////
    function automatic logic [7:0] ev_bits(input logic [7:0] v, input logic prev);
        return {v[7], v[6] ^ prev, 3'b000, v[3] & ~v[2], v[1:0]};
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (failures == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Idle cycle after each access so no strobe is set and cleared at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req_in <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk_in);
        bus_req_in <= '0;
        @(posedge sys_clk_in);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus_req_in <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk_in);
        bus_req_in <= '0;
        @(negedge sys_clk_in);
        d = rd_data_out;
        @(posedge sys_clk_in);
    endtask
    initial begin
        model = 8'h00;
        cmp_q = 1'b0;
        repeat (10) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        @(posedge sys_clk_in);
        // Random events, sometimes frozen, then read and rewrite
        repeat (150) begin
            p = $random(seed);
            en = ($random(seed) & 3) != 0;
            if (!en) p[6] = cmp_q;
            clk_en_in <= en;
            periph_in <= pef_periph_t'(p);
            @(posedge sys_clk_in);
            if (en) model = model | ev_bits(p, cmp_q);
            cmp_q = p[6];
            clk_en_in <= 1'b1;
            periph_in <= pef_periph_t'(p & 8'h74);
            rd(PEF_FLAGS_ADDR, got);
            check(got, model | (p & 8'h30));
            p = $random(seed);
            wr(PEF_FLAGS_ADDR, p);
            model = p & PEF_STICKY_MASK;
        end
        rd(8'h20, got);
        check(got, 8'h00);
        // Interrupt masked in, then out; status read clears
        for (int i = 0; i < 2; i++) begin
            wr(PEF_IRQ_MASK_ADDR, i ? 8'h00 : 8'hFF);
            rd(PEF_IRQ_MASK_ADDR, got);
            check(got, i ? 8'h00 : PEF_IMPL_MASK);
            rd(PEF_IRQ_STATUS_ADDR, got);
            rd(PEF_IRQ_STATUS_ADDR, got);
            check(got, 8'h00);
            periph_in.period_match <= 1'b1;
            @(posedge sys_clk_in);
            periph_in.period_match <= 1'b0;
            @(negedge sys_clk_in);
            check({7'h00, irq_out}, i ? 8'h00 : 8'h01);
            @(posedge sys_clk_in);
            rd(PEF_IRQ_STATUS_ADDR, got);
            check(got, 8'h02);
        end
        // Zero write and timer event in one cycle: the event must win
        periph_in <= '0;
        @(posedge sys_clk_in);
        wr(PEF_FLAGS_ADDR, 8'h00);
        periph_in.wide_timer_overflow <= 1'b1;
        bus_req_in <= '{PEF_FLAGS_ADDR, 8'h00, 1'b1, 1'b0};
        @(posedge sys_clk_in);
        periph_in.wide_timer_overflow <= 1'b0;
        rd(PEF_FLAGS_ADDR, got);
        check(got, 8'h01);
        // Status read meeting an event keeps it; an rx rising edge counts too
        periph_in.period_match <= 1'b1;
        periph_in.serial_rx_full <= 1'b1;
        bus_req_in <= '{PEF_IRQ_STATUS_ADDR, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk_in);
        periph_in.period_match <= 1'b0;
        rd(PEF_IRQ_STATUS_ADDR, got);
        check(got, 8'h22);
        // Mid-run reset clears flags, status, mask and the interrupt
        periph_in.period_match <= 1'b1;
        wr(PEF_IRQ_MASK_ADDR, 8'hFF);
        periph_in.period_match <= 1'b0;
        wr(PEF_FLAGS_ADDR, 8'hFF);
        @(negedge sys_clk_in);
        check({7'h00, irq_out}, 8'h01);
        @(posedge sys_clk_in);
        resetn_in <= 1'b0;
        repeat (2) @(posedge sys_clk_in);
        resetn_in <= 1'b1;
        @(negedge sys_clk_in);
        check({7'h00, irq_out}, 8'h00);
        @(posedge sys_clk_in);
        rd(PEF_FLAGS_ADDR, got);
        check(got, 8'h20);
        rd(PEF_IRQ_STATUS_ADDR, got);
        check(got, 8'h00);
        rd(PEF_IRQ_MASK_ADDR, got);
        check(got, 8'h00);
        results();
    end
endmodule
